// file: rtl/timer_buffer_event_irq_control.sv
// Control slice of a 16-bit timer: buffer-valid flags, event decoding, interrupt flags.
// Assumes the counter core supplies update, compare, top and bottom strobes on clk.
//
// How it works
// - Writing a compare buffer sets that channel's valid flag, bits 1 to 3.
// - An update clears all compare buffer valid flags.
// - Writing the period buffer sets the period valid flag, bit 0.
// - An update clears the period valid flag.
// - Writing ones to the set register sets flags; zeros change nothing.
// - Writing ones to the clear register clears flags; zeros change nothing.
// - Event A acts only when enabled, as its action field selects.
// - A codes: rising edge count, both edges count, count prescaled ticks while high.
// - A code 3 counts ticks, direction up when low, captured at counts.
// - Event B acts only when enabled, as its action field selects.
// - B code 0 idle, 3 steers direction while counting follows A.
// - B codes 4, 5, 6 restart on rising edge, both edges, while high.
// - Enable bits 4 to 6 gate the compare channel interrupt requests.
// - Enable bit 0 gates the wrap interrupt request.
// - Flags hold compares at bits 4 to 6 and wrap at bit 0.
// - A compare match sets that channel's flag in every mode.
// - Top or bottom sets the wrap flag, as the waveform mode selects.
// - Flags only clear by writing one; writing zero has no effect.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
module timer_buffer_event_irq_control
   import timer_ctl_pkg::*;
(
   // Clock and reset.
   input  wire logic                clk,
   input  wire logic                rst,
   // Register port.
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic      [DATA_W-1:0]   rdata_q,
   // Counter core strobes.
   input  wire logic                update,
   input  wire logic                tick,
   input  wire logic [NUM_CMP-1:0]  cmp_match,
   input  wire logic                top_hit,
   input  wire logic                bottom_hit,
   input  wire logic                wrap_on_top,
   input  wire logic                wrap_on_bottom,
   // Event inputs.
   input  wire logic                ev_a,
   input  wire logic                ev_b,
   // Counter controls.
   output logic                     count_q,
   output logic                     dir_down_q,
   output logic                     restart_q,
   output logic                     ev_dir_ctl_q,
   // Buffer-valid state.
   output logic [3:0]               buffer_valid_q,
   // Interrupt requests.
   output logic [NUM_CMP-1:0]       cmp_irq_q,
   output logic                     wrap_irq_q
);
   logic [7:0] event_input_control_q;
   logic [7:0] interrupt_enable_q;
   logic [7:0] interrupt_flags_q;
   logic [3:0] buffer_valid_d;
   logic [7:0] flags_d;
   logic       a_lvl;
   logic       a_rise;
   logic       a_any;
   logic       b_lvl;
   logic       b_rise;
   logic       b_any;
   logic [2:0] act_a;
   logic [2:0] act_b;
   logic       a_en;
   logic       b_en;
   logic       cnt_d;
   logic       dir_sel;
   logic       rst_d;
   logic       steer;
   logic       a_event_steered_direction;
   logic [3:0] buf_wr;

   function automatic logic wr_at(input logic [5:0] a, input logic [5:0] ofs);
      wr_at = (a == ofs) || (a == ofs + 6'h01);
   endfunction

   event_edge u_ev_a (
      .clk     (clk),
      .rst     (rst),
      .ev_in   (ev_a),
      .level_q (a_lvl),
      .rise_q  (a_rise),
      .any_q   (a_any)
   );

   event_edge u_ev_b (
      .clk     (clk),
      .rst     (rst),
      .ev_in   (ev_b),
      .level_q (b_lvl),
      .rise_q  (b_rise),
      .any_q   (b_any)
   );

   // Buffer writes: either byte of a 16-bit buffer counts as a new value.
   assign buf_wr[BV_PER_BIT] = wr && wr_at(addr, OFS_PER_BUF_LO);
   genvar g;
   generate
      for (g = 0; g < NUM_CMP; g++) begin : g_cmp
         assign buf_wr[BV_COMPARE_CHANNEL_0_IRQ_BIT+g] = wr && wr_at(addr, OFS_CMP_BUF_LO + 6'(2*g));
      end
   endgenerate

   // Sets win over clears so a write in the update cycle is not lost.
   always_comb begin
      buffer_valid_d = buffer_valid_q;
      if (update) begin
         buffer_valid_d = 4'h0;
      end
      if (wr && addr == OFS_BUF_CLR) begin
         buffer_valid_d = buffer_valid_d & ~wdata[3:0];
      end
      if (wr && addr == OFS_BUF_SET) begin
         buffer_valid_d = buffer_valid_d | wdata[3:0];
      end
      buffer_valid_d = buffer_valid_d | buf_wr;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         buffer_valid_q <= 4'h0;
      end else begin
         buffer_valid_q <= buffer_valid_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         event_input_control_q <= RST_REG;
         interrupt_enable_q    <= RST_REG;
      end else if (wr) begin
         if (addr == OFS_EV_CTRL) begin
            event_input_control_q <= wdata;
         end
         if (addr == OFS_INT_EN) begin
            interrupt_enable_q <= wdata & INT_MASK;
         end
      end
   end

   // Interrupt flags: hardware set beats the software clear.
   always_comb begin
      flags_d = interrupt_flags_q;
      if (wr && addr == OFS_INT_FLAGS) begin
         flags_d = flags_d & ~(wdata & INT_MASK);
      end
      flags_d[INT_COMPARE_CHANNEL_0_IRQ_BIT +: NUM_CMP] = flags_d[INT_COMPARE_CHANNEL_0_IRQ_BIT +: NUM_CMP] | cmp_match;
      if ((top_hit && wrap_on_top) || (bottom_hit && wrap_on_bottom)) begin
         flags_d[INT_WRAP_BIT] = 1'b1;
      end
      flags_d = flags_d & INT_MASK;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         interrupt_flags_q <= RST_REG;
      end else begin
         interrupt_flags_q <= flags_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmp_irq_q  <= '0;
         wrap_irq_q <= 1'b0;
      end else begin
         cmp_irq_q  <= flags_d[INT_COMPARE_CHANNEL_0_IRQ_BIT +: NUM_CMP]
                     & interrupt_enable_q[INT_COMPARE_CHANNEL_0_IRQ_BIT +: NUM_CMP];
         wrap_irq_q <= flags_d[INT_WRAP_BIT] & interrupt_enable_q[INT_WRAP_BIT];
      end
   end

   // Event decoding.
   assign a_en  = event_input_control_q[EV_A_EN_BIT];
   assign b_en  = event_input_control_q[EV_B_EN_BIT];
   assign act_a = event_input_control_q[EV_A_LSB +: 3];
   assign act_b = event_input_control_q[EV_B_LSB +: 3];
   assign steer = b_en && act_b == ACT_B_EVENT_STEERED_DIRECTION;
   assign a_event_steered_direction = a_en && act_a == ACT_A_EVENT_STEERED_DIRECTION;

   always_comb begin
      cnt_d   = 1'b0;
      dir_sel = a_lvl;
      rst_d   = 1'b0;
      if (a_en) begin
         case (act_a)
            ACT_A_RISE:   cnt_d = a_rise;
            ACT_A_BOTH:   cnt_d = a_any;
            ACT_A_HIGH:   cnt_d = tick && a_lvl;
            ACT_A_EVENT_STEERED_DIRECTION: cnt_d = tick;
            default:      cnt_d = 1'b0;
         endcase
      end
      if (steer) begin
         dir_sel = b_lvl;
      end
      if (b_en) begin
         case (act_b)
            ACT_B_RST_RISE: rst_d = b_rise;
            ACT_B_RST_BOTH: rst_d = b_any;
            ACT_B_RST_HIGH: rst_d = b_lvl;
            default:        rst_d = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_q      <= 1'b0;
         restart_q    <= 1'b0;
         ev_dir_ctl_q <= 1'b0;
      end else begin
         count_q      <= cnt_d;
         restart_q    <= rst_d;
         ev_dir_ctl_q <= steer || a_event_steered_direction;
      end
   end

   // Direction is captured only when a count happens.
   always_ff @(posedge clk) begin
      if (rst) begin
         dir_down_q <= 1'b0;
      end else if (cnt_d && (steer || a_event_steered_direction)) begin
         dir_down_q <= dir_sel;
      end
   end

   // Read data in the cycle after the strobe.
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (rd) begin
         case (addr)
            OFS_BUF_CLR, OFS_BUF_SET: rdata_q <= {4'h0, buffer_valid_q};
            OFS_EV_CTRL:              rdata_q <= event_input_control_q;
            OFS_INT_EN:               rdata_q <= interrupt_enable_q;
            OFS_INT_FLAGS:            rdata_q <= interrupt_flags_q;
            default:                  rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // Checks.
   AST_CMP_BV_SET: assert property (@(posedge clk) disable iff (rst)
      buf_wr[1] |=> buffer_valid_q[1]) else $error("compare 0 valid not set");
   AST_UPD_CLR: assert property (@(posedge clk) disable iff (rst)
      update && !wr |=> buffer_valid_q == 4'h0) else $error("update did not clear valid");
   AST_PER_BV_SET: assert property (@(posedge clk) disable iff (rst)
      buf_wr[0] |=> buffer_valid_q[0]) else $error("period valid not set");
   AST_SET_REG: assert property (@(posedge clk) disable iff (rst)
      wr && addr == OFS_BUF_SET |=> (buffer_valid_q & $past(wdata[3:0])) == $past(wdata[3:0]))
      else $error("set register failed");
   AST_CLR_REG: assert property (@(posedge clk) disable iff (rst)
      wr && addr == OFS_BUF_CLR && !update && buf_wr == 4'h0 |=>
      buffer_valid_q == ($past(buffer_valid_q) & ~$past(wdata[3:0])))
      else $error("clear register failed");
   AST_A_OFF: assert property (@(posedge clk) disable iff (rst)
      !a_en |=> !count_q) else $error("count while event A disabled");
   AST_RISE_CNT: assert property (@(posedge clk) disable iff (rst)
      a_en && act_a == ACT_A_RISE && a_rise |=> count_q) else $error("rising edge not counted");
   AST_RESTART: assert property (@(posedge clk) disable iff (rst)
      b_en && act_b == ACT_B_RST_HIGH && b_lvl |=> restart_q) else $error("no restart");
   AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (rst)
      interrupt_flags_q[INT_WRAP_BIT] && !(wr && addr == OFS_INT_FLAGS) |=>
      interrupt_flags_q[INT_WRAP_BIT]) else $error("flag cleared by itself");
   AST_IRQ: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> wrap_irq_q == ($past(flags_d[INT_WRAP_BIT])
                              && $past(interrupt_enable_q[INT_WRAP_BIT])))
      else $error("wrap request wrong");
   AST_RSVD: assert property (@(posedge clk) disable iff (rst)
      (interrupt_flags_q & ~INT_MASK) == 8'h00) else $error("reserved flag bits set");

   // Buffer-valid and flag checks per compare channel.
   generate
      for (g = 0; g < NUM_CMP; g++) begin : g_chk
         AST_CMP_N_FLAG: assert property (@(posedge clk) disable iff (rst)
            cmp_match[g] |=> interrupt_flags_q[INT_COMPARE_CHANNEL_0_IRQ_BIT+g])
            else $error("compare flag not set");
         AST_CMP_N_BV: assert property (@(posedge clk) disable iff (rst)
            buf_wr[BV_COMPARE_CHANNEL_0_IRQ_BIT+g] |=> buffer_valid_q[BV_COMPARE_CHANNEL_0_IRQ_BIT+g])
            else $error("compare buffer valid not set");
      end
   endgenerate
   // An update clears the period flag unless a set lands in the same cycle.
   AST_UPD_PER: assert property (@(posedge clk) disable iff (rst)
      update && !buf_wr[BV_PER_BIT] && !(wr && addr == OFS_BUF_SET) |=>
      !buffer_valid_q[BV_PER_BIT]) else $error("update did not clear period valid");

   // Event checks.
   AST_BOTH_CNT: assert property (@(posedge clk) disable iff (rst)
      a_en && act_a == ACT_A_BOTH && a_any |=> count_q)
      else $error("event edge not counted");
   AST_HIGH_CNT: assert property (@(posedge clk) disable iff (rst)
      a_en && act_a == ACT_A_HIGH |=> count_q == ($past(tick) && $past(a_lvl)))
      else $error("high level count wrong");
   AST_EVENT_STEERED_DIRECTION_A: assert property (@(posedge clk) disable iff (rst)
      a_event_steered_direction && !steer |=> count_q == $past(tick)
      && (!$past(tick) || dir_down_q == $past(a_lvl)))
      else $error("up-down count or direction wrong");
   AST_RSVD_A: assert property (@(posedge clk) disable iff (rst)
      act_a > ACT_A_EVENT_STEERED_DIRECTION |=> !count_q) else $error("reserved count code acted");
   AST_B_OFF: assert property (@(posedge clk) disable iff (rst)
      !b_en |=> !restart_q) else $error("restart while event B disabled");
   AST_STEER: assert property (@(posedge clk) disable iff (rst)
      steer && cnt_d |=> dir_down_q == $past(b_lvl)) else $error("event B did not steer");
   AST_RISE_B: assert property (@(posedge clk) disable iff (rst)
      b_en && act_b == ACT_B_RST_RISE && b_rise |=> restart_q)
      else $error("rising edge restart missing");
   AST_RSVD_B: assert property (@(posedge clk) disable iff (rst)
      act_b < ACT_B_RST_RISE || act_b > ACT_B_RST_HIGH |=> !restart_q)
      else $error("restart on a code without restart");

   // Interrupt checks.
   AST_CMP_IRQ: assert property (@(posedge clk) disable iff (rst)
      cmp_match[0] && interrupt_enable_q[INT_COMPARE_CHANNEL_0_IRQ_BIT] |=> cmp_irq_q[0])
      else $error("compare 0 request missing");
   AST_WRAP_EN: assert property (@(posedge clk) disable iff (rst)
      !interrupt_enable_q[INT_WRAP_BIT] |=> !wrap_irq_q)
      else $error("wrap request while disabled");
   AST_FLAG_READ: assert property (@(posedge clk) disable iff (rst)
      rd && addr == OFS_INT_FLAGS |=> rdata_q == $past(interrupt_flags_q))
      else $error("flag read wrong");
   AST_WRAP_SET: assert property (@(posedge clk) disable iff (rst)
      bottom_hit && wrap_on_bottom |=> interrupt_flags_q[INT_WRAP_BIT])
      else $error("bottom did not set wrap flag");
   AST_WRAP_ONLY: assert property (@(posedge clk) disable iff (rst)
      !(top_hit && wrap_on_top) && !(bottom_hit && wrap_on_bottom)
      && !interrupt_flags_q[INT_WRAP_BIT] |=> !interrupt_flags_q[INT_WRAP_BIT])
      else $error("wrap flag set without top or bottom");

   COV_UPDATE: cover property (@(posedge clk) disable iff (rst) update && buffer_valid_q != 0);
   COV_IRQ: cover property (@(posedge clk) disable iff (rst) cmp_irq_q[2]);
   COV_STEER: cover property (@(posedge clk) disable iff (rst) steer && cnt_d);
   COV_RESTART: cover property (@(posedge clk) disable iff (rst) restart_q);
   COV_WRAP: cover property (@(posedge clk) disable iff (rst) wrap_irq_q);
endmodule

// file: rtl/timer_ctl_pkg.sv
// Constants for the timer control slice: register offsets, field positions, codes.
// Assumes an 8-bit register port addressed by byte offset.
package timer_ctl_pkg;
   localparam int          ADDR_W            = 6;
   localparam int          DATA_W            = 8;
   localparam logic [5:0]  OFS_BUF_CLR       = 6'h06;
   localparam logic [5:0]  OFS_BUF_SET       = 6'h07;
   localparam logic [5:0]  OFS_EV_CTRL       = 6'h09;
   localparam logic [5:0]  OFS_INT_EN        = 6'h0a;
   localparam logic [5:0]  OFS_INT_FLAGS     = 6'h0b;
   localparam logic [5:0]  OFS_PER_BUF_LO    = 6'h36;
   localparam logic [5:0]  OFS_CMP_BUF_LO    = 6'h38;
   localparam logic [7:0]  RST_REG           = 8'h00;
   localparam int          BV_PER_BIT        = 0;
   localparam int          BV_COMPARE_CHANNEL_0_IRQ_BIT       = 1;
   localparam logic [7:0]  BV_MASK           = 8'h0f;
   localparam int          EV_A_EN_BIT       = 0;
   localparam int          EV_A_LSB          = 1;
   localparam int          EV_B_EN_BIT       = 4;
   localparam int          EV_B_LSB          = 5;
   localparam int          INT_WRAP_BIT      = 0;
   localparam int          INT_COMPARE_CHANNEL_0_IRQ_BIT      = 4;
   localparam logic [7:0]  INT_MASK          = 8'h71;
   localparam logic [2:0]  ACT_A_RISE        = 3'h0;
   localparam logic [2:0]  ACT_A_BOTH        = 3'h1;
   localparam logic [2:0]  ACT_A_HIGH        = 3'h2;
   localparam logic [2:0]  ACT_A_EVENT_STEERED_DIRECTION      = 3'h3;
   localparam logic [2:0]  ACT_B_NONE        = 3'h0;
   localparam logic [2:0]  ACT_B_EVENT_STEERED_DIRECTION      = 3'h3;
   localparam logic [2:0]  ACT_B_RST_RISE    = 3'h4;
   localparam logic [2:0]  ACT_B_RST_BOTH    = 3'h5;
   localparam logic [2:0]  ACT_B_RST_HIGH    = 3'h6;
   localparam int          NUM_CMP           = 3;
endpackage

// file: rtl/event_edge.sv
// Event input conditioner: two-flop synchroniser and edge detection.
// Assumes the event arrives from outside the clock domain.
`timescale 1ns/1ns
module event_edge
   import timer_ctl_pkg::*;
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst,
   // Event.
   input  wire logic ev_in,
   output logic      level_q,
   output logic      rise_q,
   output logic      any_q
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q  <= 1'b0;
         sync_q  <= 1'b0;
         level_q <= 1'b0;
         rise_q  <= 1'b0;
         any_q   <= 1'b0;
      end else begin
         meta_q  <= ev_in;
         sync_q  <= meta_q;
         level_q <= sync_q;
         rise_q  <= sync_q & ~level_q;
         any_q   <= sync_q ^ level_q;
      end
   end
endmodule

// file: verif/ev_net.sv
// Event network model: hands the bench's two event requests to the timer as levels.
// Assumes the bench sets the requests; the levels move off the clock edge.
`timescale 1ns/1ns
module ev_net (
   // Requests from the bench.
   input  wire logic a_req,
   input  wire logic b_req,
   // Event levels to the timer.
   output logic      ev_a,
   output logic      ev_b
);
   // The skew keeps event edges clear of the timer clock, as a routed event would be.
   assign #3 ev_a = a_req;
   assign #3 ev_b = b_req;
endmodule

// file: verif/tb.sv
// Bench for the timer control slice: registers, buffer flags, events, interrupts.
// Assumes the event network model and the design package are compiled first.
`timescale 1ns/1ns
module tb
   import timer_ctl_pkg::*;
;
   logic              clk = 0, rst = 1, wr = 0, rd = 0, update = 0, tick = 0;
   logic              top_hit = 0, bottom_hit = 0, wot = 0, wob = 0, a_req = 0, b_req = 0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata_q;
   logic [2:0]        cmp_match = '0, cmp_irq_q;
   logic              ev_a, ev_b, count_q, dir_down_q, restart_q, ev_dir_ctl_q, wrap_irq_q;
   logic [3:0]        buffer_valid_q;
   int                err_count = 0, cmp_count = 0, c, r;
   int                er[8] = '{1, 1, 2, 2, 0, 0, 0, 0};
   int                ef[8] = '{0, 1, 0, 2, 0, 0, 0, 0};
   int                eb[8] = '{0, 0, 0, 0, 1, 1, 1, 0};
   int                fb[8] = '{0, 0, 0, 0, 0, 1, 0, 0};

   always #5 clk = ~clk;

   timer_buffer_event_irq_control uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata_q(rdata_q), .update(update), .tick(tick),
      .cmp_match(cmp_match), .top_hit(top_hit), .bottom_hit(bottom_hit),
      .wrap_on_top(wot), .wrap_on_bottom(wob), .ev_a(ev_a), .ev_b(ev_b),
      .count_q(count_q), .dir_down_q(dir_down_q), .restart_q(restart_q),
      .ev_dir_ctl_q(ev_dir_ctl_q), .buffer_valid_q(buffer_valid_q),
      .cmp_irq_q(cmp_irq_q), .wrap_irq_q(wrap_irq_q));

   ev_net net (.a_req(a_req), .b_req(b_req), .ev_a(ev_a), .ev_b(ev_b));

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", e, rdata_q);
   endtask

   task automatic strobe(input logic [2:0] m, input logic t, input logic b);
      @(posedge clk);
      cmp_match <= m;
      top_hit <= t;
      bottom_hit <= b;
      @(posedge clk);
      cmp_match <= '0;
      top_hit <= 1'b0;
      bottom_hit <= 1'b0;
      @(posedge clk);
   endtask

   // Fourteen cycles of watching; ticks come late so the event has settled by then.
   task automatic run(input int t, output int cn, output int rn);
      cn = 0;
      rn = 0;
      for (int i = 0; i < 14; i++) begin
         @(posedge clk);
         tick <= (i >= 8 && i < 8 + t);
         #1 cn += int'(count_q);
         rn += int'(restart_q);
      end
   endtask

   task automatic regs_test;
      rd_chk(OFS_EV_CTRL, 8'h00);
      rd_chk(OFS_INT_EN, 8'h00);
      rd_chk(OFS_INT_FLAGS, 8'h00);
      rd_chk(6'h3f, 8'h00);
      wr_reg(OFS_EV_CTRL, 8'ha5);
      rd_chk(OFS_EV_CTRL, 8'ha5);
   endtask

   task automatic buf_test;
      #1 chk("bv", 8'h00, {4'h0, buffer_valid_q});
      wr_reg(OFS_CMP_BUF_LO, 8'h5a);
      #1 chk("bv", 8'h02, {4'h0, buffer_valid_q});
      wr_reg(6'h3d, 8'ha5);
      #1 chk("bv", 8'h0a, {4'h0, buffer_valid_q});
      wr_reg(6'h37, 8'h11);
      #1 chk("bv", 8'h0b, {4'h0, buffer_valid_q});
      wr_reg(OFS_BUF_SET, 8'hf4);
      #1 chk("bv", 8'h0f, {4'h0, buffer_valid_q});
      wr_reg(OFS_BUF_CLR, 8'h02);
      #1 chk("bv", 8'h0d, {4'h0, buffer_valid_q});
      @(posedge clk);
      update <= 1'b1;
      @(posedge clk);
      update <= 1'b0;
      #1 chk("bv", 8'h00, {4'h0, buffer_valid_q});
   endtask

   task automatic ev_a_test;
      for (int en = 0; en < 2; en++) begin
         for (int k = 0; k < 8; k++) begin
            wr_reg(OFS_EV_CTRL, {4'h0, 3'(k), 1'(en)});
            a_req <= 1'b1;
            run(2, c, r);
            chk("count_rise", en ? 8'(er[k]) : 8'h00, 8'(c));
            if (en == 1 && k == 3) chk("dir", 8'h01, {7'h0, dir_down_q});
            a_req <= 1'b0;
            run(2, c, r);
            chk("count_fall", en ? 8'(ef[k]) : 8'h00, 8'(c));
            if (en == 1 && k == 3) chk("dir", 8'h00, {7'h0, dir_down_q});
         end
      end
   endtask

   task automatic ev_b_test;
      for (int k = 0; k < 8; k++) begin
         wr_reg(OFS_EV_CTRL, {3'(k), 5'h10});
         b_req <= 1'b1;
         run(2, c, r);
         chk("restart_rise", 8'(eb[k]), k == 6 ? 8'(r >= 8) : 8'(r));
         chk("count_b", 8'h00, 8'(c));
         b_req <= 1'b0;
         run(2, c, r);
         chk("restart_fall", 8'(fb[k]), k == 6 ? 8'(r > 4) : 8'(r));
      end
      wr_reg(OFS_EV_CTRL, 8'h07);
      b_req <= 1'b1;
      run(2, c, r);
      chk("restart_off", 8'h00, 8'(r));
      wr_reg(OFS_EV_CTRL, 8'h77);
      run(2, c, r);
      chk("steer", 8'h32, {2'h0, ev_dir_ctl_q, dir_down_q, 4'(c)});
      b_req <= 1'b0;
   endtask

   task automatic irq_test;
      wr_reg(OFS_INT_EN, 8'hff);
      wot <= 1'b1;
      rd_chk(OFS_INT_EN, 8'h71);
      strobe(3'b111, 1'b1, 1'b0);
      #1 chk("irq", 8'h0f, {4'h0, cmp_irq_q, wrap_irq_q});
      rd_chk(OFS_INT_FLAGS, 8'h71);
      wr_reg(OFS_INT_FLAGS, 8'h00);
      rd_chk(OFS_INT_FLAGS, 8'h71);
      wr_reg(OFS_INT_FLAGS, 8'h20);
      rd_chk(OFS_INT_FLAGS, 8'h51);
      wr_reg(OFS_INT_EN, 8'h10);
      @(posedge clk);
      #1 chk("irq", 8'h02, {4'h0, cmp_irq_q, wrap_irq_q});
      wr_reg(OFS_INT_FLAGS, 8'hff);
      wr_reg(OFS_INT_EN, 8'h01);
      wot <= 1'b0;
      strobe(3'b000, 1'b0, 1'b1);
      wob <= 1'b1;
      rd_chk(OFS_INT_FLAGS, 8'h00);
      strobe(3'b000, 1'b0, 1'b1);
      #1 chk("irq", 8'h01, {4'h0, cmp_irq_q, wrap_irq_q});
      rd_chk(OFS_INT_FLAGS, 8'h01);
   endtask

   task stop_test;
      $display("Compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #200000;
      err_count++;
      stop_test();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      regs_test();
      buf_test();
      ev_a_test();
      ev_b_test();
      irq_test();
      stop_test();
   end
endmodule
